// >>> hw/epsc_pkg.sv
// Constants, types and sequence memory image of the embedded power sequence controller
package epsc_pkg;

  localparam int MCLK_HZ = 10_000_000;
  localparam int RC_HZ = 32768;
  localparam int TICK_DIV = MCLK_HZ / RC_HZ;
  localparam int TICK_W = $clog2(TICK_DIV);
  localparam int NUM_RES = 16;
  localparam int OTP_DEPTH = 16;
  localparam int NUM_GPIO = 3;
  localparam int GPIO_RES_BASE = 13;

  localparam logic [1:0] CRC_SKIP = 2'h0;
  localparam logic [1:0] CRC_CONT = 2'h1;
  localparam logic [1:0] CRC_VIO = 2'h2;
  localparam logic [1:0] CRC_HOLD = 2'h3;

  typedef enum logic [2:0] {
    off_to_active_seq,
    active_to_off_seq,
    sleep_to_off_seq,
    active_to_sleep_seq,
    sleep_to_active_seq
  } epsc_seq_e;

  typedef enum logic [1:0] {PS_OFF, PS_ACTIVE, PS_SLEEP} epsc_pwr_e;

  typedef struct packed {
    logic last;
    logic vio;
    logic [3:0] addr;
    logic [7:0] data;
  } epsc_entry_s;

  typedef struct packed {
    logic on;
    logic off;
    logic wake;
    logic sleep;
  } epsc_req_s;

  typedef logic [NUM_RES-1:0][7:0] epsc_res_t;

  // Resource 0 is the always-on domain
  localparam epsc_res_t RES_DEFAULT = {{(NUM_RES-1){8'h00}}, 8'h01};

  localparam logic [3:0] SEQ_START [5] = '{4'h0, 4'h5, 4'h8, 4'ha, 4'hc};

  localparam epsc_entry_s OTP_IMAGE [OTP_DEPTH] = '{
    14'h0101, 14'h0201, 14'h1301, 14'h0401, 14'h2d01,
    14'h0d00, 14'h0400, 14'h2300,
    14'h0100, 14'h2300,
    14'h0402, 14'h2e01,
    14'h0401, 14'h2e00,
    14'h2f00, 14'h2f00
  };

  function automatic epsc_entry_s otp_sum_f();
    epsc_entry_s s;
    s = '0;
    for (int i = 0; i < OTP_DEPTH; i++)
    begin
      s = s ^ OTP_IMAGE[i];
    end
    return s;
  endfunction

  localparam epsc_entry_s OTP_SUM = otp_sum_f();

endpackage

// >>> hw/epsc_otp.sv
// Sequence memory with integrity scanner
`timescale 1ns/10ps
`default_nettype none
module epsc_otp (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] rd_addr,
  output var epsc_pkg::epsc_entry_s rd_entry,
  input wire logic upset,
  input wire logic chk_start,
  output logic chk_done,
  output logic chk_err
);
  import epsc_pkg::*;

  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    epsc_entry_s acc;
    logic done;
    logic err;
  } epsc_otp_s;

  epsc_otp_s r;
  epsc_otp_s n;
  epsc_entry_s mem [OTP_DEPTH];

  // Upset flips one stored bit to model a disturbed fuse
  always_comb
  begin
    for (int i = 0; i < OTP_DEPTH; i++)
    begin
      mem[i] = OTP_IMAGE[i];
    end
    mem[0].data[0] = OTP_IMAGE[0].data[0] ^ upset;
  end

  assign rd_entry = mem[rd_addr];

  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (chk_start)
    begin
      n.busy = 1'b1;
      n.idx = 4'h0;
      n.acc = '0;
    end
    else if (r.busy)
    begin
      n.acc = r.acc ^ mem[r.idx];
      n.idx = r.idx + 4'h1;
      if (r.idx == 4'(OTP_DEPTH - 1))
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.err = (r.acc ^ mem[r.idx]) != OTP_SUM;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= n;
  end

  assign chk_done = r.done;
  assign chk_err = r.err;

  // Start is registered once, the scan then walks all entries one per cycle
  scan_length_a: assert property (@(posedge mclk) disable iff (!resetn)
    chk_start |-> ##17 chk_done)
    else $error("integrity scan did not end after sixteen entries");

endmodule
`default_nettype wire

// >>> hw/epsc_core.sv
// Embedded power controller: arbitration, power state machine and sequencer
`timescale 1ns/10ps
`default_nettype none
module epsc_core (
  input wire logic mclk,
  input wire logic resetn,
  input wire epsc_pkg::epsc_req_s req_in,
  input wire logic supply_ok_in,
  input wire logic hot_die_in,
  input wire logic crc_en,
  input wire logic [1:0] crc_mode,
  input wire logic otp_upset,
  input wire logic host_wr,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_data,
  input wire logic otp_err_clr,
  output var epsc_pkg::epsc_res_t res_q,
  output logic [epsc_pkg::NUM_GPIO-1:0] gpio_en,
  output var epsc_pkg::epsc_pwr_e pwr_state,
  output var epsc_pkg::epsc_seq_e seq_id,
  output logic seq_busy,
  output logic req_reject,
  output logic otp_err_flag
);
  import epsc_pkg::*;

  typedef enum logic [1:0] {SQ_IDLE, SQ_CHECK, SQ_RUN} epsc_sq_e;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [TICK_W-1:0] div;
    logic tick;
    epsc_pwr_e pstate;
    epsc_sq_e sstate;
    epsc_seq_e seq;
    logic [3:0] ptr;
    logic crc_fail;
    logic hold;
    epsc_req_s last_win;
    logic reject;
    logic err_flag;
    logic check_go;
    epsc_res_t res;
  } epsc_core_s;

  localparam epsc_core_s CORE_RST = '{pstate: PS_OFF, sstate: SQ_IDLE, seq: off_to_active_seq,
                                      res: RES_DEFAULT, default: '0};

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic epsc_req_s arb_f(epsc_req_s q);
    epsc_req_s w;
    w = '0;
    if (q.off)
      w.off = 1'b1;
    else if (q.sleep)
      w.sleep = 1'b1;
    else if (q.wake)
      w.wake = 1'b1;
    else if (q.on)
      w.on = 1'b1;
    return w;
  endfunction

  function automatic logic [3:0] pick_f(epsc_pwr_e ps, epsc_req_s w, logic ok, logic hot, logic hold);
    logic [3:0] p;
    p = 4'h0;
    case (ps)
      PS_OFF:
      begin
        if (w.on && ok && !hot && !hold)
          p = {1'b1, off_to_active_seq};
      end
      PS_ACTIVE:
      begin
        if (w.off)
          p = {1'b1, active_to_off_seq};
        else if (w.sleep)
          p = {1'b1, active_to_sleep_seq};
      end
      PS_SLEEP:
      begin
        if (w.off)
          p = {1'b1, sleep_to_off_seq};
        else if (w.wake)
          p = {1'b1, sleep_to_active_seq};
      end
      default: p = 4'h0;
    endcase
    return p;
  endfunction

  function automatic epsc_pwr_e target_f(epsc_seq_e s);
    epsc_pwr_e t;
    case (s)
      off_to_active_seq: t = PS_ACTIVE;
      sleep_to_active_seq: t = PS_ACTIVE;
      active_to_sleep_seq: t = PS_SLEEP;
      default: t = PS_OFF;
    endcase
    return t;
  endfunction

  epsc_core_s r;
  epsc_core_s n;
  epsc_req_s req_s;
  epsc_req_s win;
  logic ok_s;
  logic hot_s;
  logic [3:0] pick;
  logic go;
  epsc_seq_e go_seq;
  epsc_entry_s entry;
  logic chk_done;
  logic chk_err;

  assign req_s = r.sync2[3:0];
  assign ok_s = r.sync2[4];
  assign hot_s = r.sync2[5];
  assign win = arb_f(req_s);
  assign pick = pick_f(r.pstate, win, ok_s, hot_s, r.hold);
  assign go = pick[3];
  assign go_seq = epsc_seq_e'(pick[2:0]);

  epsc_otp u_otp (
    .mclk(mclk),
    .resetn(resetn),
    .rd_addr(r.ptr),
    .rd_entry(entry),
    .upset(otp_upset),
    .chk_start(r.check_go),
    .chk_done(chk_done),
    .chk_err(chk_err)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sync1 = {hot_die_in, supply_ok_in, req_in};
    n.sync2 = r.sync1;
    n.tick = 1'b0;
    n.reject = 1'b0;
    n.check_go = 1'b0;
    // Tick divider stands in for the low-frequency oscillator
    if (r.div == TICK_W'(TICK_DIV - 1))
    begin
      n.div = '0;
      n.tick = 1'b1;
    end
    else
      n.div = r.div + TICK_W'(1);
    if (host_wr)
      n.res[host_addr] = host_data;
    if (otp_err_clr)
      n.err_flag = 1'b0;
    if (chk_done && chk_err)
      n.err_flag = 1'b1;
    if (!req_s.on)
      n.hold = 1'b0;
    case (r.sstate)
      SQ_IDLE:
      begin
        n.last_win = win;
        if (go)
        begin
          n.seq = go_seq;
          n.ptr = SEQ_START[go_seq];
          n.crc_fail = 1'b0;
          if (go_seq == off_to_active_seq && crc_en && crc_mode != CRC_SKIP)
          begin
            n.sstate = SQ_CHECK;
            n.check_go = 1'b1;
          end
          else
            n.sstate = SQ_RUN;
        end
        else if (win != '0 && win != r.last_win)
          n.reject = 1'b1;
      end
      SQ_CHECK:
      begin
        if (chk_done)
        begin
          if (chk_err && crc_mode == CRC_HOLD)
          begin
            n.sstate = SQ_IDLE;
            n.hold = 1'b1;
          end
          else
          begin
            n.sstate = SQ_RUN;
            n.crc_fail = chk_err && crc_mode == CRC_VIO;
          end
        end
      end
      SQ_RUN:
      begin
        // Sequencer write overrides a host write to the same resource
        if (r.tick)
        begin
          n.res[entry.addr] = entry.data;
          n.ptr = r.ptr + 4'h1;
          if (entry.last)
          begin
            n.sstate = SQ_IDLE;
            n.pstate = target_f(r.seq);
          end
          else if (r.crc_fail && entry.vio)
          begin
            n.sstate = SQ_IDLE;
            n.hold = 1'b1;
          end
        end
      end
      default: n.sstate = SQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      r <= CORE_RST;
    else
      r <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign res_q = r.res;
  assign pwr_state = r.pstate;
  assign seq_id = r.seq;
  assign seq_busy = r.sstate != SQ_IDLE;
  assign req_reject = r.reject;
  assign otp_err_flag = r.err_flag;

  genvar g;
  generate
    for (g = 0; g < NUM_GPIO; g++)
    begin : gen_gpio
      assign gpio_en[g] = r.res[GPIO_RES_BASE + g][0];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int TICK_N = TICK_DIV;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  step_on_tick_a: assert property (
    (r.sstate == SQ_RUN && !r.tick) |=> r.ptr == $past(r.ptr))
    else $error("sequencer stepped without a tick");

  ptr_advance_a: assert property (
    (r.sstate == SQ_RUN && r.tick) |=> r.ptr == $past(r.ptr) + 4'h1)
    else $error("access list pointer did not advance by one");

  tick_period_a: assert property (
    r.tick |-> ##[TICK_N:TICK_N] r.tick)
    else $error("tick period wrong");

  off_wins_a: assert property (
    (r.sstate == SQ_IDLE && r.pstate == PS_ACTIVE && req_s.off) |=>
      (r.sstate == SQ_RUN && r.seq == active_to_off_seq))
    else $error("off request did not start power-down");

  seq_result_a: assert property (
    $changed(r.pstate) |-> ($past(r.sstate) == SQ_RUN && r.pstate == target_f($past(r.seq))))
    else $error("power state changed outside a finished sequence");

  legal_move_a: assert property (
    $changed(r.pstate) |-> !($past(r.pstate) == PS_OFF && r.pstate == PS_SLEEP))
    else $error("illegal power state move");

  one_seq_a: assert property (
    (r.sstate != SQ_IDLE && $past(r.sstate) != SQ_IDLE) |-> $stable(r.seq))
    else $error("sequence changed while busy");

  check_first_a: assert property (
    (r.sstate == SQ_IDLE && go && go_seq == off_to_active_seq && crc_en && crc_mode != CRC_SKIP)
      |=> (r.sstate == SQ_CHECK && r.check_go) ##1 !r.check_go)
    else $error("integrity check not run before power-up");

  err_flag_a: assert property (
    (chk_done && chk_err) |=> r.err_flag)
    else $error("integrity error not flagged");

  res_source_a: assert property (
    $changed(r.res) |-> $past(host_wr || (r.sstate == SQ_RUN && r.tick)))
    else $error("resource changed without host or sequencer write");

  hot_gate_a: assert property (
    (r.sstate == SQ_IDLE && r.pstate == PS_OFF && (hot_s || !ok_s)) |=> r.sstate == SQ_IDLE)
    else $error("power-up started under a gating condition");

  single_win_a: assert property (
    $onehot0(win) && (req_s.off -> win.off))
    else $error("arbitration winner not unique");

  powerup_done_c: cover property (r.sstate == SQ_RUN && r.seq == off_to_active_seq ##1 r.pstate == PS_ACTIVE);
  sleep_entry_c: cover property ($rose(r.pstate == PS_SLEEP));
  crc_error_c: cover property (chk_done && chk_err);
  reject_c: cover property (r.reject);

endmodule
`default_nettype wire

// >>> test/epsc_host_model.sv
// Host-side model issuing static resource writes
`timescale 1ns/10ps
`default_nettype none
module epsc_host_model (
  input wire logic mclk,
  output logic host_wr,
  output logic [3:0] host_addr,
  output logic [7:0] host_data
);
  initial
  begin
    host_wr = 1'b0;
    host_addr = 4'h0;
    host_data = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_data <= d;
    @(posedge mclk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_data <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench of the power sequence controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import epsc_pkg::*;
  localparam epsc_req_s ON_R = 4'h8;
  localparam epsc_req_s OFF_R = 4'h4;
  localparam epsc_req_s WAKE_R = 4'h2;
  localparam epsc_req_s SLP_R = 4'h1;
  localparam logic [3:0] UP_A [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hd};
  logic mclk;
  logic resetn;
  epsc_req_s req_in;
  logic supply_ok_in;
  logic hot_die_in;
  logic crc_en;
  logic [1:0] crc_mode;
  logic otp_upset;
  logic otp_err_clr;
  logic host_wr;
  logic [3:0] host_addr;
  logic [7:0] host_data;
  epsc_res_t res_q;
  logic [NUM_GPIO-1:0] gpio_en;
  epsc_pwr_e pwr_state;
  epsc_seq_e seq_id;
  logic seq_busy;
  logic req_reject;
  logic otp_err_flag;
  int miscompares = 0;
  int checks = 0;

  epsc_core dut_u (.mclk(mclk), .resetn(resetn), .req_in(req_in), .supply_ok_in(supply_ok_in),
    .hot_die_in(hot_die_in), .crc_en(crc_en), .crc_mode(crc_mode), .otp_upset(otp_upset),
    .host_wr(host_wr), .host_addr(host_addr), .host_data(host_data), .otp_err_clr(otp_err_clr),
    .res_q(res_q), .gpio_en(gpio_en), .pwr_state(pwr_state), .seq_id(seq_id),
    .seq_busy(seq_busy), .req_reject(req_reject), .otp_err_flag(otp_err_flag));
  epsc_host_model host_u (.mclk(mclk), .host_wr(host_wr), .host_addr(host_addr), .host_data(host_data));

  // ------------------------------
  // Compare and report
  // ------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Request held only until the sequence starts; busy blocks re-evaluation
  task automatic run(input epsc_req_s r, input epsc_seq_e s, input epsc_pwr_e p);
    int n;
    n = 0;
    @(posedge mclk);
    req_in <= r;
    while (seq_busy !== 1'b1 && n < 10)
    begin
      @(negedge mclk);
      n++;
    end
    chk1("seq_busy", 1'b1, seq_busy);
    chk8("seq_id", 8'(s), 8'(seq_id));
    @(posedge mclk);
    req_in <= '0;
    n = 0;
    while (seq_busy !== 1'b0 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    chk1("seq_busy end", 1'b0, seq_busy);
    chk8("pwr_state", 8'(p), 8'(pwr_state));
    repeat (4) @(posedge mclk);
  endtask
  task automatic rej(input epsc_req_s r);
    logic seen;
    seen = 1'b0;
    @(posedge mclk);
    req_in <= r;
    repeat (8)
    begin
      @(negedge mclk);
      if (req_reject === 1'b1)
        seen = 1'b1;
    end
    chk1("req_reject", 1'b1, seen);
    chk1("seq_busy", 1'b0, seq_busy);
    @(posedge mclk);
    req_in <= '0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_reset();
    @(negedge mclk);
    for (int i = 0; i < NUM_RES; i++)
      chk8("res_q", RES_DEFAULT[i], res_q[i]);
    chk8("pwr_state", 8'(PS_OFF), 8'(pwr_state));
    chk1("otp_err_flag", 1'b0, otp_err_flag);
  endtask
  task automatic t_gate();
    @(posedge mclk);
    supply_ok_in <= 1'b0;
    rej(ON_R);
    @(posedge mclk);
    supply_ok_in <= 1'b1;
    hot_die_in <= 1'b1;
    rej(ON_R);
    @(posedge mclk);
    hot_die_in <= 1'b0;
    rej(SLP_R);
  endtask
  task automatic t_up();
    int a;
    int b;
    a = 0;
    b = 0;
    host_u.write(4'h5, 8'h5a);
    host_u.write(4'hf, 8'h01);
    fork
      run(ON_R, off_to_active_seq, PS_ACTIVE);
      begin
        while (res_q[1] !== 8'h01 && a < 3000)
        begin
          @(negedge mclk);
          a++;
        end
        while (res_q[2] !== 8'h01 && b < 3000)
        begin
          @(negedge mclk);
          b++;
        end
        chk1("tick spacing", 1'b1, b == TICK_DIV);
      end
    join
    foreach (UP_A[i])
      chk8("res_q up", 8'h01, res_q[UP_A[i]]);
    chk1("gpio_en0", 1'b1, gpio_en[0]);
    chk1("gpio_en2", 1'b1, gpio_en[2]);
    chk8("res_q5", 8'h5a, res_q[5]);
    chk8("res_q6", 8'h00, res_q[6]);
  endtask
  task automatic t_sleep();
    rej(WAKE_R);
    run(SLP_R, active_to_sleep_seq, PS_SLEEP);
    chk8("res_q4", 8'h02, res_q[4]);
    chk1("gpio_en1", 1'b1, gpio_en[1]);
    rej(ON_R);
    run(WAKE_R, sleep_to_active_seq, PS_ACTIVE);
    chk8("res_q4", 8'h01, res_q[4]);
    chk1("gpio_en1", 1'b0, gpio_en[1]);
    run(SLP_R, active_to_sleep_seq, PS_SLEEP);
    run(OFF_R, sleep_to_off_seq, PS_OFF);
    chk8("res_q1", 8'h00, res_q[1]);
    chk8("res_q5", 8'h5a, res_q[5]);
  endtask
  task automatic t_arb();
    rej(OFF_R | ON_R);
    run(ON_R, off_to_active_seq, PS_ACTIVE);
    run(OFF_R | SLP_R, active_to_off_seq, PS_OFF);
    chk1("gpio_en0", 1'b0, gpio_en[0]);
    chk8("res_q4", 8'h00, res_q[4]);
  endtask
  task automatic t_crc();
    @(posedge mclk);
    crc_en <= 1'b1;
    otp_upset <= 1'b1;
    crc_mode <= CRC_HOLD;
    run(ON_R, off_to_active_seq, PS_OFF);
    chk1("otp_err_flag", 1'b1, otp_err_flag);
    chk8("res_q4", 8'h00, res_q[4]);
    @(posedge mclk);
    otp_err_clr <= 1'b1;
    crc_mode <= CRC_CONT;
    @(posedge mclk);
    otp_err_clr <= 1'b0;
    @(negedge mclk);
    chk1("otp_err_flag", 1'b0, otp_err_flag);
    run(ON_R, off_to_active_seq, PS_ACTIVE);
    chk1("otp_err_flag", 1'b1, otp_err_flag);
    chk1("gpio_en0", 1'b1, gpio_en[0]);
  endtask
  // Error with abort at the marked entry: steps up to it land, the rest do not
  task automatic t_vio();
    run(OFF_R, active_to_off_seq, PS_OFF);
    @(posedge mclk);
    crc_mode <= CRC_VIO;
    run(ON_R, off_to_active_seq, PS_OFF);
    chk8("res_q2", 8'h01, res_q[2]);
    chk8("res_q3", 8'h01, res_q[3]);
    chk8("res_q4", 8'h00, res_q[4]);
    chk1("gpio_en0", 1'b0, gpio_en[0]);
    chk1("otp_err_flag", 1'b1, otp_err_flag);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Whole run needs about 10000 cycles
  initial
  begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    final_report();
  end
  initial
  begin
    resetn = 1'b0;
    req_in = '0;
    supply_ok_in = 1'b1;
    hot_die_in = 1'b0;
    crc_en = 1'b0;
    crc_mode = CRC_SKIP;
    otp_upset = 1'b0;
    otp_err_clr = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_gate();
    t_up();
    t_sleep();
    t_arb();
    t_crc();
    t_vio();
    final_report();
  end
endmodule
`default_nettype wire
